// ### logic/ttc_regs.svh
// Offsets, field positions, reset values and timing constants of the block
`ifndef TTC_REGS_SVH
`define TTC_REGS_SVH

`define TTC_ADDR_W 8
`define TTC_OFS_OUT_EN 8'h02
`define TTC_OFS_SLEEP_MOD 8'h03
`define TTC_OFS_CHK_LIM 8'h04

`define TTC_RST_OUT_EN 8'h7B
`define TTC_RST_SLEEP_MOD 8'h28
`define TTC_RST_CHK_LIM 8'h50

`define TTC_BIT_CLK_ON 0
`define TTC_BIT_SUPPLY_ON 1
`define TTC_BIT_ASK 7
`define TTC_BIT_SLEEP_STRETCH 1
`define TTC_BIT_LIMIT_STRETCH 0

`define TTC_SLEEP_UNIT 1024
`define TTC_SLEEP_STRETCH_MUL 8
`define TTC_LIMIT_STRETCH_MUL 2
`define TTC_LIM_MIN_FLOOR 6'h0A
`define TTC_LIM_MIN_MAX 6'h3F

`define TTC_DIV_RANGE0 4'h8
`define TTC_DIV_RANGE1 4'h4
`define TTC_DIV_RANGE2 4'h2
`define TTC_DIV_RANGE3 4'h1

`define TTC_CHK_N0 4'h0
`define TTC_CHK_N1 4'h3
`define TTC_CHK_N2 4'h6
`define TTC_CHK_N3 4'h9

`endif

// ### logic/ttc_pkg.sv
// Types shared by the timing control register bank
package ttc_pkg;

  typedef enum logic [1:0] {
    TTC_OP_IDLE = 2'b00,
    TTC_OP_TX = 2'b01,
    TTC_OP_RX_POLL = 2'b10,
    TTC_OP_RX = 2'b11
  } ttc_op_t;

  typedef struct packed {
    logic [5:0] freq_msb;
    logic supply_out_en;
    logic clk_out_en;
  } ttc_out_en_t;

  typedef struct packed {
    logic amplitude_keying_select;
    logic [4:0] sleep_time;
    logic sleep_stretch;
    logic limit_stretch;
  } ttc_sleep_mod_t;

  typedef struct packed {
    logic [1:0] verify_bit_count;
    logic [5:0] lim_min;
  } ttc_chk_lim_t;

  typedef struct packed {
    logic bit_check_ok;
    logic [4:0] key_event;
    logic power_on_status;
  } ttc_auto_set_t;

endpackage : ttc_pkg

// ### logic/ttc_sleep_timer.sv
// Receive polling sleep interval timer
`timescale 1ns/100ps
`include "ttc_regs.svh"
module ttc_sleep_timer import ttc_pkg::*; #(
  parameter int SLEEP_UNIT = `TTC_SLEEP_UNIT
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic base_timing_clock_tick,
  input wire logic start,
  input wire logic [4:0] sleep_time,
  input wire logic sleep_stretch,
  output logic busy,
  output logic done
);

  localparam int CW = 24;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] target;
  logic next_busy;
  logic next_done;

  // Sleep length in base clock periods, stretch applied
  always_comb begin
    target = CW'(sleep_time) * CW'(SLEEP_UNIT);
    if (sleep_stretch) begin
      target = target * CW'(`TTC_SLEEP_STRETCH_MUL);
    end
  end

  always_comb begin
    next_count = count;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      next_count = '0;
      next_busy = 1'b1;
    end else if (busy && base_timing_clock_tick) begin
      // Zero sleep ends on the first base tick
      if (count + CW'(1) >= target) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count + CW'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule : ttc_sleep_timer

// ### logic/ttc_bit_clock.sv
// Scaled bit clock, minimum limit time and transmit half-bit ticks
`timescale 1ns/100ps
`include "ttc_regs.svh"
module ttc_bit_clock import ttc_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic base_timing_clock_tick,
  input wire logic [1:0] baud_range,
  input wire logic limit_stretch,
  input wire logic [5:0] lim_min,
  input wire logic tx_run,
  output logic scaled_bit_clock_tick,
  output logic tx_half_bit,
  output logic [9:0] min_limit_base_timing_clock
);

  logic [3:0] div;
  logic [4:0] period;
  logic [4:0] pre;
  logic [4:0] next_pre;
  logic [6:0] baud_cnt;
  logic [6:0] next_baud_cnt;
  logic next_scaled_bit_clock_tick;
  logic next_tx_half_bit;
  logic [9:0] next_min_limit_base_timing_clock;

  always_comb begin
    case (baud_range)
      2'd0: div = `TTC_DIV_RANGE0;
      2'd1: div = `TTC_DIV_RANGE1;
      2'd2: div = `TTC_DIV_RANGE2;
      default: div = `TTC_DIV_RANGE3;
    endcase
    // Limit stretch doubles the bit clock period
    period = limit_stretch ? {div, 1'b0} : {1'b0, div};
  end

  always_comb begin
    next_pre = pre;
    next_scaled_bit_clock_tick = 1'b0;
    next_baud_cnt = baud_cnt;
    next_tx_half_bit = 1'b0;
    // Minimum limit expressed in base clock periods
    next_min_limit_base_timing_clock = 10'(lim_min) * 10'(period);
    if (base_timing_clock_tick) begin
      if (pre + 5'd1 >= period) begin
        next_pre = '0;
        next_scaled_bit_clock_tick = 1'b1;
      end else begin
        next_pre = pre + 5'd1;
      end
    end
    // Half bit lasts lim_min+1 bit clock periods
    if (!tx_run) begin
      next_baud_cnt = '0;
    end else if (scaled_bit_clock_tick) begin
      if (baud_cnt >= 7'(lim_min)) begin
        next_baud_cnt = '0;
        next_tx_half_bit = 1'b1;
      end else begin
        next_baud_cnt = baud_cnt + 7'd1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pre <= '0;
      scaled_bit_clock_tick <= 1'b0;
      baud_cnt <= '0;
      tx_half_bit <= 1'b0;
      min_limit_base_timing_clock <= '0;
    end else if (ce) begin
      pre <= next_pre;
      scaled_bit_clock_tick <= next_scaled_bit_clock_tick;
      baud_cnt <= next_baud_cnt;
      tx_half_bit <= next_tx_half_bit;
      min_limit_base_timing_clock <= next_min_limit_base_timing_clock;
    end
  end

endmodule : ttc_bit_clock

// ### logic/ttc_top.sv
// Timing control register bank: clock enable, modulation, sleep, limits
// Function
// - Output-enable register bit 0 gates clock output; resets to 1.
// - Bit check OK (receive modes only), key event or power-on flag forces clock enable on.
// - Bit 7 of sleep register selects ASK (1) or FSK (0, reset).
// - Sleep field bits 6:2, reset 10; sleep = value x 1024 x stretch.
// - Sleep stretch bit 1: 0 gives factor one, 1 gives eight.
// - Limit stretch bit 0: 0 gives factor one, 1 doubles limit times.
// - Bits 7:6 choose bits checked: 0, 3 (reset), 6 or 9.
// - Receive: bits 5:0 give minimum limit in bit clocks, reset 16.
// - Transmit: same field sets baud as 1/((value+1) x period x 2).
// - Bit clock = base period x limit stretch x range divisor 8/4/2/1.
`timescale 1ns/100ps
`include "ttc_regs.svh"
module ttc_top import ttc_pkg::*; #(
  parameter int SLEEP_UNIT = `TTC_SLEEP_UNIT
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic base_timing_clock_tick,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic [1:0] op_mode,
  input wire logic baud_range_select_hi,
  input wire logic baud_range_select_lo,
  input wire logic bit_check_ok,
  input wire logic [4:0] key_input_event,
  input wire logic power_on_status,
  output logic clk_out_en,
  output logic supply_out_en,
  output logic amplitude_keying_select,
  output logic [3:0] verify_bit_count,
  output logic [9:0] min_limit_base_timing_clock,
  output logic lim_min_invalid,
  output logic scaled_bit_clock_tick,
  output logic tx_half_bit,
  output logic poll_sleeping,
  output logic poll_listening
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  ttc_out_en_t out_en;
  ttc_out_en_t next_out_en;
  ttc_sleep_mod_t sleep_mod;
  ttc_sleep_mod_t next_sleep_mod;
  ttc_chk_lim_t chk_lim;
  ttc_chk_lim_t next_chk_lim;
  ttc_auto_set_t auto_set;
  logic force_on;
  logic [7:0] next_reg_rd_data;
  logic next_reg_rd_valid;
  ttc_op_t mode;

  assign mode = ttc_op_t'(op_mode);
  assign auto_set.bit_check_ok = bit_check_ok;
  assign auto_set.key_event = key_input_event;
  assign auto_set.power_on_status = power_on_status;

  // Bit check success only counts while the receiver is in use
  always_comb begin
    force_on = 1'b0;
    if (auto_set.bit_check_ok &&
        (mode == TTC_OP_RX || mode == TTC_OP_RX_POLL)) begin
      force_on = 1'b1;
    end
    if (|auto_set.key_event || auto_set.power_on_status) begin
      force_on = 1'b1;
    end
  end

  always_comb begin
    next_out_en = out_en;
    next_sleep_mod = sleep_mod;
    next_chk_lim = chk_lim;
    if (reg_wr_en) begin
      case (reg_addr)
        `TTC_OFS_OUT_EN: next_out_en = ttc_out_en_t'(reg_wr_data);
        `TTC_OFS_SLEEP_MOD: begin
          next_sleep_mod = ttc_sleep_mod_t'(reg_wr_data);
        end
        `TTC_OFS_CHK_LIM: begin
          next_chk_lim = ttc_chk_lim_t'(reg_wr_data);
        end
        default: begin
        end
      endcase
    end
    // Forced set wins over a software clear in the same cycle
    if (force_on) begin
      next_out_en.clk_out_en = 1'b1;
      next_out_en.supply_out_en = 1'b1;
    end
  end

  always_comb begin
    next_reg_rd_valid = reg_rd_en;
    case (reg_addr)
      `TTC_OFS_OUT_EN: next_reg_rd_data = out_en;
      `TTC_OFS_SLEEP_MOD: next_reg_rd_data = sleep_mod;
      `TTC_OFS_CHK_LIM: next_reg_rd_data = chk_lim;
      default: next_reg_rd_data = 8'h00;
    endcase
    if (!reg_rd_en) begin
      next_reg_rd_data = reg_rd_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      out_en <= ttc_out_en_t'(`TTC_RST_OUT_EN);
      sleep_mod <= ttc_sleep_mod_t'(`TTC_RST_SLEEP_MOD);
      chk_lim <= ttc_chk_lim_t'(`TTC_RST_CHK_LIM);
      reg_rd_data <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else if (ce) begin
      out_en <= next_out_en;
      sleep_mod <= next_sleep_mod;
      chk_lim <= next_chk_lim;
      reg_rd_data <= next_reg_rd_data;
      reg_rd_valid <= next_reg_rd_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded controls

  assign clk_out_en = out_en.clk_out_en;
  assign supply_out_en = out_en.supply_out_en;
  assign amplitude_keying_select = sleep_mod.amplitude_keying_select;

  always_comb begin
    case (chk_lim.verify_bit_count)
      2'd0: verify_bit_count = `TTC_CHK_N0;
      2'd1: verify_bit_count = `TTC_CHK_N1;
      2'd2: verify_bit_count = `TTC_CHK_N2;
      default: verify_bit_count = `TTC_CHK_N3;
    endcase
  end

  // Out-of-range values are flagged, not corrected, so software sees them
  assign lim_min_invalid = chk_lim.lim_min < `TTC_LIM_MIN_FLOOR;

  ////////////////////////////////////////////////////////////////////////
  // Bit clock and limit timing

  ttc_bit_clock u_bit_clock (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .base_timing_clock_tick(base_timing_clock_tick),
    .baud_range({baud_range_select_hi, baud_range_select_lo}),
    .limit_stretch(sleep_mod.limit_stretch),
    .lim_min(chk_lim.lim_min),
    .tx_run(mode == TTC_OP_TX),
    .scaled_bit_clock_tick(scaled_bit_clock_tick),
    .tx_half_bit(tx_half_bit),
    .min_limit_base_timing_clock(min_limit_base_timing_clock)
  );

  ////////////////////////////////////////////////////////////////////////
  // Receive polling sequencer

  typedef enum logic [1:0] {
    POLL_OFF,
    POLL_SLEEP,
    POLL_LISTEN,
    POLL_HOLD
  } ttc_poll_t;

  ttc_poll_t poll_state;
  ttc_poll_t next_poll_state;
  logic sleep_start;
  logic next_sleep_start;
  logic sleep_busy;
  logic sleep_done;

  // A failed check keeps listening without re-arming the sleep; only success moves on to hold
  always_comb begin
    next_poll_state = poll_state;
    next_sleep_start = 1'b0;
    case (poll_state)
      POLL_OFF: begin
        if (mode == TTC_OP_RX_POLL) begin
          next_poll_state = POLL_SLEEP;
          next_sleep_start = 1'b1;
        end
      end
      POLL_SLEEP: begin
        if (sleep_done) begin
          next_poll_state = POLL_LISTEN;
        end
      end
      POLL_LISTEN: begin
        if (bit_check_ok) begin
          next_poll_state = POLL_HOLD;
        end
      end
      POLL_HOLD: begin
      end
      default: next_poll_state = POLL_OFF;
    endcase
    if (mode != TTC_OP_RX_POLL) begin
      next_poll_state = POLL_OFF;
      next_sleep_start = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      poll_state <= POLL_OFF;
      sleep_start <= 1'b0;
    end else if (ce) begin
      poll_state <= next_poll_state;
      sleep_start <= next_sleep_start;
    end
  end

  ttc_sleep_timer #(
    .SLEEP_UNIT(SLEEP_UNIT)
  ) u_sleep_timer (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .base_timing_clock_tick(base_timing_clock_tick),
    .start(sleep_start),
    .sleep_time(sleep_mod.sleep_time),
    .sleep_stretch(sleep_mod.sleep_stretch),
    .busy(sleep_busy),
    .done(sleep_done)
  );

  assign poll_sleeping = poll_state == POLL_SLEEP && sleep_busy;
  assign poll_listening = poll_state == POLL_LISTEN;

endmodule : ttc_top

// ### testbench/ttc_top_sva.sv
// Port assertions for the timing control register bank
`timescale 1ns/100ps
module ttc_top_sva (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [1:0] op_mode,
  input wire logic bit_check_ok,
  input wire logic [4:0] key_input_event,
  input wire logic power_on_status,
  input wire logic clk_out_en,
  input wire logic amplitude_keying_select,
  input wire logic [3:0] verify_bit_count,
  input wire logic lim_min_invalid,
  input wire logic poll_sleeping,
  input wire logic poll_listening
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic auto;
  logic wr3;
  logic wr4;
  // Any forcing source; a write then loses to the set
  assign auto = (|key_input_event) || power_on_status
    || (bit_check_ok && op_mode[1]);
  assign wr3 = ce && reg_wr_en && reg_addr == 8'h03;
  assign wr4 = ce && reg_wr_en && reg_addr == 8'h04;
  property p_rst_val;
    $fell(srst) |-> clk_out_en && !amplitude_keying_select
      && verify_bit_count == 4'h3;
  endproperty
  a_rst_val: assert property (p_rst_val)
    else $error("reset value wrong");
  property p_key;
    ce && (|key_input_event) |=> clk_out_en;
  endproperty
  a_key: assert property (p_key)
    else $error("key event did not enable clock");
  property p_pwr;
    ce && power_on_status |=> clk_out_en;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power-on did not enable clock");
  property p_chk;
    ce && bit_check_ok && op_mode[1] |=> clk_out_en;
  endproperty
  a_chk: assert property (p_chk)
    else $error("bit check did not enable clock");
  property p_clk_wr;
    ce && reg_wr_en && reg_addr == 8'h02 && !auto
      |=> clk_out_en == $past(reg_wr_data[0]);
  endproperty
  a_clk_wr: assert property (p_clk_wr)
    else $error("clock enable write lost");
  property p_ask_wr;
    wr3 |=> amplitude_keying_select == $past(reg_wr_data[7]);
  endproperty
  a_ask_wr: assert property (p_ask_wr)
    else $error("modulation select write lost");
  property p_cnt_wr;
    wr4 |=> verify_bit_count == 4'h3 * $past(reg_wr_data[7:6]);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr)
    else $error("bit count decode wrong");
  property p_inv_wr;
    wr4 |=> lim_min_invalid == ($past(reg_wr_data[5:0]) < 6'h0A);
  endproperty
  a_inv_wr: assert property (p_inv_wr)
    else $error("limit range flag wrong");
  property p_hold;
    ce && !reg_wr_en |=> $stable(amplitude_keying_select)
      && $stable(verify_bit_count);
  endproperty
  a_hold: assert property (p_hold)
    else $error("field changed without write");
  property p_poll;
    !(poll_sleeping && poll_listening);
  endproperty
  a_poll: assert property (p_poll)
    else $error("sleep and listen together");
endmodule : ttc_top_sva

// ### testbench/ttc_host_model.sv
// Host side of the register port
`timescale 1ns/100ps
module ttc_host_model (
  input wire logic clock,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr <= a;
    // Never hand the device a limit below its floor
    reg_wr_data <= (a == 8'h04 && d[5:0] < 6'h0A) ? {d[7:6], 6'h0A} : d;
    reg_wr_en <= 1'b1;
    @(negedge clock);
    reg_wr_en <= 1'b0;
    // Released data is scrambled so no stale value looks valid
    reg_wr_data <= ~reg_wr_data;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
    output logic ok);
    @(negedge clock);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(negedge clock);
    reg_rd_en <= 1'b0;
    ok = reg_rd_valid;
    d = reg_rd_data;
  endtask : rd
endmodule : ttc_host_model

// ### testbench/tb_ttc_top.sv
// Self-checking bench for the timing control register bank
`timescale 1ns/100ps
`include "ttc_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_ttc_top import ttc_pkg::*;;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic base_timing_clock_tick = 1'b1;
  logic reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [1:0] op_mode = 2'h0;
  logic hi = 1'b1;
  logic lo = 1'b0;
  logic bit_check_ok = 1'b0;
  logic [4:0] key_input_event = 5'h00;
  logic power_on_status = 1'b0;
  logic clk_out_en, supply_out_en, amplitude_keying_select;
  logic [3:0] verify_bit_count;
  logic [9:0] min_limit_base_timing_clock;
  logic lim_min_invalid, scaled_bit_clock_tick, tx_half_bit;
  logic poll_sleeping, poll_listening;
  int failures = 0;
  int n_checks = 0;
  int seed = 32'h17cf;
  int n, k, xd, r;
  logic [7:0] d, v;
  logic [5:0] lim;
  logic ok;
  always #5 clock = ~clock;
  ttc_top #(.SLEEP_UNIT(4)) i_ttc_top (.clock(clock), .srst(srst),
    .ce(ce), .base_timing_clock_tick(base_timing_clock_tick), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .op_mode(op_mode),
    .baud_range_select_hi(hi), .baud_range_select_lo(lo),
    .bit_check_ok(bit_check_ok), .key_input_event(key_input_event),
    .power_on_status(power_on_status), .clk_out_en(clk_out_en),
    .supply_out_en(supply_out_en),
    .amplitude_keying_select(amplitude_keying_select),
    .verify_bit_count(verify_bit_count), .min_limit_base_timing_clock(min_limit_base_timing_clock),
    .lim_min_invalid(lim_min_invalid), .scaled_bit_clock_tick(scaled_bit_clock_tick),
    .tx_half_bit(tx_half_bit), .poll_sleeping(poll_sleeping),
    .poll_listening(poll_listening));
  ttc_host_model i_ttc_host_model (.clock(clock),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data));
  ////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    i_ttc_host_model.rd(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask : rdchk
  // Period of the next pulse train, bounded only once its first pulse has arrived
  task automatic gap(input bit tx, output int p);
    int c;
    p = 0;
    c = 0;
    while (c < 2 && p < 4000) begin
      @(negedge clock);
      if (tx ? tx_half_bit : scaled_bit_clock_tick) c++;
      if (c == 1) p++;
    end
    if (c < 2) begin
      failures++;
      final_report();
    end
  endtask : gap
  function automatic int f_xd(input logic [1:0] rng, input logic xl);
    return (8 >> rng) * (xl ? 2 : 1);
  endfunction : f_xd
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock) srst = 1'b0;
    rdchk(8'h02, `TTC_RST_OUT_EN);
    rdchk(8'h03, `TTC_RST_SLEEP_MOD);
    rdchk(8'h04, `TTC_RST_CHK_LIM);
    rdchk(8'h07, 8'h00);
    `CHK(min_limit_base_timing_clock, 10'(16 * f_xd(2'h2, 1'b0)))
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      r = $random(seed);
      lim = (i == 0) ? 6'h0A : (i == 1) ? 6'h3F : 6'(10 + {r} % 54);
      {hi, lo} = r[9:8];
      i_ttc_host_model.wr(8'h03, v);
      i_ttc_host_model.wr(8'h04, {r[7:6], lim});
      repeat (3) @(negedge clock);
      xd = f_xd(r[9:8], v[0]);
      `CHK(amplitude_keying_select, v[7])
      `CHK(verify_bit_count, 4'h3 * r[7:6])
      `CHK(min_limit_base_timing_clock, 10'(lim * xd))
      `CHK(lim_min_invalid, 1'b0)
      rdchk(8'h03, v);
      op_mode = 2'h1;
      gap(1'b1, n);
      `CHK(n, (lim + 1) * 2 * xd / 2)
      gap(1'b0, n);
      `CHK(n, xd)
      op_mode = 2'h0;
    end
    for (int s = 0; s < 2; s++) begin
      i_ttc_host_model.wr(8'h03, {1'b0, 5'h03, s[0], 1'b0});
      op_mode = 2'h2;
      n = 0;
      k = 0;
      while (!poll_sleeping && k < 10) begin
        @(negedge clock);
        k++;
      end
      while (poll_sleeping && n < 200) begin
        @(negedge clock);
        n++;
      end
      if (k == 10 || n == 200) begin
        failures++;
        final_report();
      end
      `CHK(n, 3 * 4 * (s ? 8 : 1))
      // Done is registered, so listening follows one cycle later
      @(negedge clock);
      `CHK(poll_listening, 1'b1)
      i_ttc_host_model.wr(8'h02, 8'h00);
      `CHK(clk_out_en, 1'b0)
      bit_check_ok = 1'b1;
      @(negedge clock);
      bit_check_ok = 1'b0;
      op_mode = 2'h0;
      `CHK(clk_out_en, 1'b1)
    end
    for (int j = 0; j < 7; j++) begin
      i_ttc_host_model.wr(8'h02, 8'h00);
      `CHK(clk_out_en, 1'b0)
      if (j < 5) key_input_event = 5'h01 << j;
      else if (j == 5) power_on_status = 1'b1;
      else {op_mode, bit_check_ok} = 3'b011;
      @(negedge clock);
      {op_mode, bit_check_ok} = 3'b000;
      key_input_event = 5'h00;
      power_on_status = 1'b0;
      `CHK(clk_out_en, j < 6)
      `CHK(supply_out_en, j < 6)
    end
    // Clock enable low must freeze the registers against a write
    ce = 1'b0;
    i_ttc_host_model.wr(8'h03, 8'h80);
    ce = 1'b1;
    rdchk(8'h03, 8'h0E);
    `CHK(amplitude_keying_select, 1'b0)
    srst = 1'b1;
    @(negedge clock);
    srst = 1'b0;
    rdchk(8'h03, `TTC_RST_SLEEP_MOD);
    final_report();
  end
endmodule : tb_ttc_top
bind ttc_top ttc_top_sva i_ttc_top_sva (.clock(clock), .srst(srst),
  .ce(ce), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .op_mode(op_mode),
  .bit_check_ok(bit_check_ok), .key_input_event(key_input_event),
  .power_on_status(power_on_status), .clk_out_en(clk_out_en),
  .amplitude_keying_select(amplitude_keying_select),
  .verify_bit_count(verify_bit_count), .lim_min_invalid(lim_min_invalid),
  .poll_sleeping(poll_sleeping), .poll_listening(poll_listening));
